//--- ioa_pkg.sv
package ioa_pkg;
  // register map
  localparam logic [11:0] IOA_OFS_COMMAND = 12'h100;
  localparam logic [11:0] IOA_OFS_WFIFO = 12'h104;
  localparam logic [11:0] IOA_OFS_ADDRESS = 12'h108;
  localparam logic [11:0] IOA_OFS_STATUS = 12'h10c;
  // command fields
  localparam int IOA_LEN_LSB = 0;
  localparam int IOA_LEN_W = 4;
  localparam int IOA_CODE_LSB = 8;
  localparam int IOA_CODE_W = 4;
  localparam int IOA_ADDR_ONLY_BIT = 12;
  localparam logic [31:0] IOA_COMMAND_RESET = 32'h0000_0000;
  localparam logic [31:0] IOA_ADDRESS_RESET = 32'h0000_0000;
  // command codes: bit 2 of code is the middle-of-transaction flag
  localparam logic [3:0] IOA_CODE_WRITE = 4'h0;
  localparam logic [3:0] IOA_CODE_READ = 4'h1;
  localparam logic [3:0] IOA_CODE_WSTATUS = 4'h2;
  localparam int IOA_MOT_BIT = 2;
  localparam int IOA_FIFO_DEPTH = 16;
  // reply codes from the sink
  localparam logic [1:0] IOA_REPLY_ACK = 2'h0;
  localparam logic [1:0] IOA_REPLY_NACK = 2'h1;
  localparam logic [1:0] IOA_REPLY_DEFER = 2'h2;
  localparam logic [1:0] IOA_REPLY_PARTIAL = 2'h3;

  typedef enum logic [1:0] {
    IOA_KIND_WRITE,
    IOA_KIND_READ,
    IOA_KIND_WSTATUS,
    IOA_KIND_ADDR
  } ioa_kind_t;

  typedef struct packed {
    ioa_kind_t kind;
    logic mot;
    logic read;
    logic [6:0] addr;
    logic [4:0] len;
  } ioa_req_t;

  typedef struct packed {
    logic [1:0] code;
    logic [4:0] count;
    logic [7:0] data;
  } ioa_reply_t;
endpackage

//--- ioa_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ioa_decode
  import ioa_pkg::*;
(
  input wire logic [31:0] i_command,
  input wire logic [6:0] i_addr,
  output ioa_req_t o_req
);
  wire logic [3:0] code = i_command[IOA_CODE_LSB +: IOA_CODE_W];
  wire logic [1:0] base = code[1:0];
  wire logic only = i_command[IOA_ADDR_ONLY_BIT];
  wire logic [3:0] len_f = i_command[IOA_LEN_LSB +: IOA_LEN_W];
  wire ioa_kind_t kind = (base == IOA_CODE_WSTATUS[1:0]) ? IOA_KIND_WSTATUS
    : only ? IOA_KIND_ADDR
    : (base == IOA_CODE_READ[1:0]) ? IOA_KIND_READ : IOA_KIND_WRITE;
  wire logic is_read = base == IOA_CODE_READ[1:0];
  // length field encodes bytes minus one; none for address-only or status
  wire logic [4:0] len_bytes = (kind == IOA_KIND_READ ||
    kind == IOA_KIND_WRITE) ? {1'b0, len_f} + 5'h01 : 5'h00;
  // one driver for the whole request word, not one per field
  assign o_req = '{kind: kind, mot: code[IOA_MOT_BIT], read: is_read,
    addr: i_addr, len: len_bytes};
endmodule
`default_nettype wire

//--- ioa_seq.sv
// Notes on behaviour
// [RULE_01] software loads the slave address register before any transaction
// [RULE_02] software fills the write fifo before a write command
// [RULE_03] command register write launches; bits 3:0 hold the length
// [RULE_04] status command sets bit 12 and sends command and address only
// [RULE_05] write or read without mot ends with stop, bus idle
// [RULE_06] read with mot addresses slave and reads, no stop
// [RULE_07] after defer or partial ack, status requests may poll progress
// [RULE_08] sink may defer a burst read while its bus read runs
// [RULE_09] after read defer, the identical read may be reissued
// [RULE_10] sink answers a repeated read with data when done
// [RULE_11] deferred read aborted by other-slave read, write, or stop
// [RULE_12] partial-ack polling: partial ack, then nack on completion
// [RULE_13] repeated partial-ack write gets ack when write completes
// [RULE_14] burst write aborted by other-slave write, read, or stop
// [RULE_15] defer polling: partial ack, then ack on completion
// [RULE_16] repeated deferred write gets defer until done, then ack
// [RULE_17] mot set leaves bus as is; cleared forces idle at end
// [RULE_18] address-only commands use bit 12 with read or write code
// [RULE_19] sink issues its own stop after a one second silence
// [RULE_20] no new request while one still awaits its reply
`timescale 1ns/1ps
`default_nettype none
module ioa_seq
  import ioa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_req_valid,
  input wire logic i_req_ready,
  output ioa_req_t o_req,
  output logic [7:0] o_req_data,
  output logic o_req_data_valid,
  input wire logic i_req_data_ready,
  input wire logic i_reply_valid,
  input wire ioa_reply_t i_reply,
  output logic o_busy,
  output logic o_bus_held
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_DATA,
    ST_WAIT
  } ioa_state_t;

  ioa_state_t state;
  ioa_state_t next_state;
  logic [31:0] command;
  logic [31:0] address;
  logic [7:0] fifo [IOA_FIFO_DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] sent;
  logic [1:0] last_code;
  logic [4:0] last_count;
  logic [7:0] read_data;
  logic held;
  logic pending;
  ioa_req_t req;

  ////////////////////////////////////////////////////////////////////////
  ioa_decode u_decode (
    .i_command(command),
    .i_addr(address[6:0]),
    .o_req(req)
  );

  wire logic hit_cmd = i_reg_addr == IOA_OFS_COMMAND;
  wire logic hit_fifo = i_reg_addr == IOA_OFS_WFIFO;
  wire logic hit_addr = i_reg_addr == IOA_OFS_ADDRESS;
  wire logic hit_stat = i_reg_addr == IOA_OFS_STATUS;
  // a launch while busy is dropped; software polls the status word first
  wire logic launch = i_reg_wr && hit_cmd && state == ST_IDLE; // [RULE_03]
  wire logic is_write = req.kind == IOA_KIND_WRITE;
  wire logic data_done = sent == req.len;
  wire logic reply_in = state == ST_WAIT && i_reply_valid;
  wire logic push = i_reg_wr && hit_fifo && state == ST_IDLE; // [RULE_02]
  wire logic pop = state == ST_DATA && i_req_data_ready && !data_done;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (launch) next_state = ST_SEND; // [RULE_20]
      ST_SEND: if (i_req_ready) begin
        next_state = (is_write && req.len != 5'h00) ? ST_DATA : ST_WAIT;
      end
      ST_DATA: if (data_done) next_state = ST_WAIT;
      ST_WAIT: if (i_reply_valid) next_state = ST_IDLE; // [RULE_20]
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) state <= ST_IDLE;
    else state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      command <= IOA_COMMAND_RESET;
      address <= IOA_ADDRESS_RESET;
    end else begin
      if (launch) command <= i_reg_wdata; // [RULE_03] [RULE_04] [RULE_18]
      if (i_reg_wr && hit_addr && state == ST_IDLE) begin
        address <= i_reg_wdata; // [RULE_01]
      end
    end
  end

  // fifo is not cleared by a launch, so a deferred write can be
  // repeated unchanged by reissuing the command alone
  always_ff @(posedge i_clock) begin
    if (push) fifo[wr_ptr] <= i_reg_wdata[7:0];
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      sent <= 5'h00;
    end else begin
      if (push) wr_ptr <= wr_ptr + 4'h1;
      if (launch) begin
        rd_ptr <= 4'h0; // [RULE_09] repeat resends same bytes
        sent <= 5'h00;
      end else if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
        sent <= sent + 5'h01;
      end
      if (reply_in && is_write && i_reply.code == IOA_REPLY_ACK) begin
        wr_ptr <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus-held tracks whether the far i2c bus is left open after a command
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held <= 1'b0;
      pending <= 1'b0;
      last_code <= IOA_REPLY_ACK;
      last_count <= 5'h00;
      read_data <= 8'h00;
    end else if (reply_in) begin
      last_code <= i_reply.code;
      last_count <= i_reply.count;
      if (i_reply.code == IOA_REPLY_DEFER ||
          i_reply.code == IOA_REPLY_PARTIAL) begin
        pending <= req.kind != IOA_KIND_ADDR; // [RULE_07] [RULE_08]
        held <= 1'b1;
      end else begin
        pending <= 1'b0; // [RULE_11] [RULE_14]
        held <= req.mot; // [RULE_05] [RULE_06] [RULE_17]
      end
      if (req.read && i_reply.code == IOA_REPLY_ACK) begin
        read_data <= i_reply.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_req_valid = state == ST_SEND;
  assign o_req = req;
  assign o_req_data = fifo[rd_ptr];
  assign o_req_data_valid = state == ST_DATA && !data_done;
  assign o_busy = state != ST_IDLE;
  assign o_bus_held = held;

  always_comb begin
    o_reg_rdata = 32'h0000_0000;
    if (i_reg_rd) begin
      if (hit_cmd) o_reg_rdata = command;
      else if (hit_addr) o_reg_rdata = address;
      else if (hit_stat) begin
        o_reg_rdata = {8'h00, read_data, 3'h0, last_count,
          pending, held, last_code, 3'h0, o_busy};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  one_request_a: assert property ( // [RULE_20]
    @(posedge i_clock) disable iff (!i_rst_n)
    state == ST_WAIT && !i_reply_valid |=> !o_req_valid)
    else $error("request issued while awaiting reply");
  launch_send_a: assert property ( // [RULE_03]
    @(posedge i_clock) disable iff (!i_rst_n)
    launch |=> o_req_valid && o_busy)
    else $error("launch did not start request");
  stop_idle_a: assert property ( // [RULE_05]
    @(posedge i_clock) disable iff (!i_rst_n)
    reply_in && !req.mot && i_reply.code == IOA_REPLY_ACK |=> !o_bus_held)
    else $error("bus not idle after stop");
  mot_hold_a: assert property ( // [RULE_17]
    @(posedge i_clock) disable iff (!i_rst_n)
    reply_in && req.mot && i_reply.code == IOA_REPLY_NACK |=> o_bus_held)
    else $error("bus not held with mot");
  read_mot_a: assert property ( // [RULE_06]
    @(posedge i_clock) disable iff (!i_rst_n)
    reply_in && req.read && req.mot |=> o_bus_held)
    else $error("mot read released bus");
  status_len_a: assert property ( // [RULE_04]
    @(posedge i_clock) disable iff (!i_rst_n)
    o_req_valid && req.kind == IOA_KIND_WSTATUS |-> req.len == 5'h00)
    else $error("status request carries length");
  defer_pend_a: assert property ( // [RULE_08]
    @(posedge i_clock) disable iff (!i_rst_n)
    reply_in && i_reply.code == IOA_REPLY_DEFER &&
    req.kind == IOA_KIND_READ |=> pending ##0 state == ST_IDLE)
    else $error("read defer not recorded");
  abort_clear_a: assert property ( // [RULE_11] [RULE_14]
    @(posedge i_clock) disable iff (!i_rst_n)
    reply_in && req.kind == IOA_KIND_ADDR && !req.mot &&
    i_reply.code == IOA_REPLY_ACK |=> !pending && !o_bus_held)
    else $error("abort left transaction open");
  retry_ptr_a: assert property ( // [RULE_09]
    @(posedge i_clock) disable iff (!i_rst_n)
    launch |=> rd_ptr == 4'h0 && sent == 5'h00)
    else $error("retry did not rewind data");
endmodule
`default_nettype wire

//--- ioa_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module ioa_sink_model
  import ioa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire ioa_req_t i_req,
  input wire logic i_data_valid,
  input wire logic [1:0] i_code,
  input wire logic [4:0] i_delay,
  output logic o_req_ready,
  output logic o_data_ready,
  output logic o_reply_valid,
  output ioa_reply_t o_reply
);
  logic armed;
  logic [4:0] left, got, wait_cnt;
  logic [14:0] rep;
  logic [7:0] rd_byte;
  logic bus_open;
  logic [26:0] quiet;
  // one second of open bus at 125 MHz before the sink stops it itself
  localparam int STOP_LIMIT = 125_000_000;
  // prompt accept; slowness lives in the reply delay
  assign o_req_ready = i_req_valid;
  assign o_data_ready = armed && left != 5'h0;
  // read data names the slave asked, so a wrong address shows up
  assign rep = {i_code, got, rd_byte};
  // outside the pulse the fields are junk, never the last value
  assign o_reply = o_reply_valid ? rep : ~rep;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
      left <= 5'h0;
      got <= 5'h0;
      wait_cnt <= 5'h0;
      rd_byte <= 8'h00;
      bus_open <= 1'b0;
      quiet <= 27'h0;
      o_reply_valid <= 1'b0;
    end else begin
      o_reply_valid <= 1'b0;
      if (i_req_valid && o_req_ready) begin
        armed <= 1'b1;
        got <= 5'h0;
        wait_cnt <= i_delay;
        rd_byte <= {1'b0, i_req.addr};
        bus_open <= i_req.mot;
        quiet <= 27'h0;
        left <= (i_req.kind == IOA_KIND_WRITE) ? i_req.len : 5'h0;
      end else if (armed && left != 5'h0) begin
        left <= left - {4'h0, i_data_valid};
        got <= got + {4'h0, i_data_valid};
      end else if (armed && wait_cnt != 5'h0) begin
        wait_cnt <= wait_cnt - 5'h1;
      end else if (armed) begin
        armed <= 1'b0;
        o_reply_valid <= 1'b1;
      end
      if (bus_open && !(i_req_valid && o_req_ready)) begin
        quiet <= quiet + 27'h1;
        if (quiet == 27'(STOP_LIMIT - 1)) bus_open <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import ioa_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [11:0] i_reg_addr = '0;
  logic [31:0] i_reg_wdata = '0;
  logic [31:0] rdata;
  logic req_valid, req_ready, data_valid, data_ready, reply_valid;
  logic busy, held, pb = 1'b0;
  ioa_req_t req;
  ioa_reply_t reply;
  logic [7:0] req_data;
  logic [1:0] code = '0;
  logic [4:0] dly = '0;
  logic [6:0] sa;
  logic [7:0] wb [16];
  ioa_req_t rq[$];
  logic [7:0] bq[$];
  logic hq[$];
  int fail_count = 0;
  int comparisons = 0;
  ioa_seq u_dut(.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(rdata), .o_req_valid(req_valid), .i_req_ready(req_ready),
    .o_req(req), .o_req_data(req_data), .o_req_data_valid(data_valid),
    .i_req_data_ready(data_ready), .i_reply_valid(reply_valid),
    .i_reply(reply), .o_busy(busy), .o_bus_held(held));
  ioa_sink_model u_sink(.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_req_valid(req_valid), .i_req(req), .i_data_valid(data_valid),
    .i_code(code), .i_delay(dly), .o_req_ready(req_ready),
    .o_data_ready(data_ready), .o_reply_valid(reply_valid), .o_reply(reply));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(negedge i_clock);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    @(negedge i_clock);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(posedge i_clock);
    chk("rdata", e, rdata);
    @(negedge i_clock);
    i_reg_rd = 1'b0;
  endtask
  // n bytes; status and address-only pass 1 and expect no length
  task automatic run(logic [3:0] c, logic ao, int n, logic ld,
                     logic [1:0] rc, logic [4:0] dl);
    ioa_kind_t k;
    int t;
    logic [4:0] el;
    k = c[1] ? IOA_KIND_WSTATUS : ao ? IOA_KIND_ADDR :
        c[0] ? IOA_KIND_READ : IOA_KIND_WRITE;
    el = (k == IOA_KIND_READ || k == IOA_KIND_WRITE) ? 5'(n) : 5'h00;
    code = rc;
    dly = dl;
    wr(IOA_OFS_ADDRESS, {25'h0, sa});
    for (int i = 0; i < n; i++) if (ld) wr(IOA_OFS_WFIFO, {24'h0, wb[i]});
    rq.push_back(ioa_req_t'{k, c[2], c[0], sa, el});
    if (k == IOA_KIND_WRITE) for (int i = 0; i < n; i++) bq.push_back(wb[i]);
    hq.push_back(c[2] || rc[1]);
    wr(IOA_OFS_COMMAND, {19'h0, ao, c, 4'h0, 4'(n - 1)});
    if (dl > 10) begin
      wr(IOA_OFS_COMMAND, {19'h0, ao, c, 4'h0, 4'(n)});
      wr(IOA_OFS_ADDRESS, 32'h0);
    end
    t = 0;
    while (busy !== 1'b0 && t < 300) begin
      @(negedge i_clock);
      t++;
    end
    if (busy !== 1'b0) begin
      chk("timeout", 32'h0, 32'h1);
      print_verdict();
    end
  endtask
  always @(negedge i_clock) begin
    ioa_req_t e;
    logic [31:0] ev;
    if (i_rst_n && req_valid && req_ready) begin
      e = rq.size() ? rq.pop_front() : '1;
      chk("request", 32'(e), 32'(req));
    end
    if (i_rst_n && data_valid && data_ready) begin
      ev = bq.size() ? 32'(bq.pop_front()) : 32'h100;
      chk("byte", ev, 32'(req_data));
    end
    if (pb && !busy) begin
      ev = hq.size() ? 32'(hq.pop_front()) : 32'h2;
      chk("held", ev, 32'(held));
    end
    pb = busy;
  end
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  initial begin
    void'($urandom(32'h8d1023da));
    sa = 7'($urandom);
    foreach (wb[i]) wb[i] = 8'($urandom);
    repeat (5) @(negedge i_clock);
    i_rst_n = 1'b1;
    rd(IOA_OFS_ADDRESS, IOA_ADDRESS_RESET);
    rd(IOA_OFS_COMMAND, IOA_COMMAND_RESET);
    run(IOA_CODE_WRITE, 0, 1, 1, IOA_REPLY_ACK, 0);
    rd(IOA_OFS_ADDRESS, {25'h0, sa});
    run(IOA_CODE_WRITE, 0, 16, 1, IOA_REPLY_ACK, 3);
    run(IOA_CODE_READ | 4'h4, 0, 4, 0, IOA_REPLY_ACK, 1);
    run(IOA_CODE_READ, 0, 2, 0, IOA_REPLY_DEFER, 2);
    run(IOA_CODE_READ, 0, 2, 0, IOA_REPLY_ACK, 20);
    rd(IOA_OFS_ADDRESS, {25'h0, sa});
    rd(IOA_OFS_STATUS, {8'h00, 1'b0, sa, 16'h0000});
    run(IOA_CODE_READ, 0, 3, 0, IOA_REPLY_DEFER, 0);
    run(IOA_CODE_WRITE, 1, 1, 0, IOA_REPLY_ACK, 0);
    run(IOA_CODE_WRITE | 4'h4, 1, 1, 0, IOA_REPLY_NACK, 0);
    run(IOA_CODE_WRITE, 0, 5, 1, IOA_REPLY_PARTIAL, 2);
    rd(IOA_OFS_STATUS, {8'h00, 1'b0, sa, 3'h0, 5'h05, 1'b1, 1'b1,
       IOA_REPLY_PARTIAL, 3'h0, 1'b0});
    run(IOA_CODE_WSTATUS | 4'h4, 1, 1, 0, IOA_REPLY_PARTIAL, 1);
    run(IOA_CODE_WSTATUS, 1, 1, 0, IOA_REPLY_NACK, 1);
    run(IOA_CODE_WRITE, 0, 5, 0, IOA_REPLY_ACK, 1);
    run(IOA_CODE_WRITE, 0, 3, 1, IOA_REPLY_DEFER, 2);
    run(IOA_CODE_WSTATUS | 4'h4, 1, 1, 0, IOA_REPLY_PARTIAL, 0);
    run(IOA_CODE_WRITE, 0, 3, 0, IOA_REPLY_DEFER, 1);
    run(IOA_CODE_WRITE, 0, 3, 0, IOA_REPLY_ACK, 1);
    run(IOA_CODE_WRITE | 4'h4, 0, 2, 1, IOA_REPLY_DEFER, 0);
    run(IOA_CODE_READ, 0, 1, 0, IOA_REPLY_ACK, 0);
    rd(12'h1f0, 32'h0);
    chk("leftover", 32'h0, 32'(rq.size() + bq.size() + hq.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
